//--- sbst_tap.sv
// Purpose: Test access port of a burst memory, on its own test clock
// Assumes: Test clock is free of the core clock; nrst_in is power-up reset
// Notes:   Updated instructions are queued to the core side
// What this block does
// [R1] Code 000 captures ring, selects boundary chain, floats memory outputs
// [R2] Code 001 loads identification word and selects it; memory unaffected
// [R3] Code 010 captures ring, selects boundary chain, floats memory outputs
// [R4] Controller never loads 011, 101 or 110; they are reserved
// [R5] Code 100 captures ring, selects boundary chain; no preload, memory unaffected
// [R6] Code 111 selects one-bit skip register; memory unaffected
// [R7] Identification bit 0 always reads 1
// [R8] Identification bits 31:28 carry revision number
// [R9] Identification bits 27:23 carry depth: 00111 wide, 01000 narrow
// [R10] Identification bits 22:18 carry width: 00100 wide, 00011 narrow
// [R11] Identification bits 11:1 carry fixed maker code for both variants
// [R12] Identification bits 17:12 carry reserved device code
// [R13] Wide chain is 70 cells; sleep 17, clock 35, burst 64, address 69/70
// [R14] Instruction register is three bits, shifted while selected
// [R15] Capture of instruction register loads 01 into two low bits
// [R16] Five rising edges with TMS high reset port, selecting identification
// [R17] Serial input sampled on rising edge, output changed on falling edge
// [R18] Sixteen-state controller stepped by TMS; output driven only while shifting
`timescale 1ns/1ns
module sbst_tap
  import sbst_pkg::*;
#(
  parameter bit        WIDE_VARIANT = 1'b1,
  parameter int        BSR_LEN      = WIDE_VARIANT ? BSR_LEN_WIDE : BSR_LEN_NARROW,
  parameter bit [3:0]  REVISION     = 4'h0,
  parameter bit [5:0]  DEVICE_CODE  = 6'h00,
  // Arbitrary maker code value
  parameter bit [10:0] MAKER_CODE   = 11'h2A5
)(
  input  wire logic               core_clk_in,
  input  wire logic               nrst_in,
  input  wire logic               tck_in,
  input  wire logic               tms_in,
  input  wire logic               tdi_in,
  output logic                    tdo_out,
  output logic                    tdo_oe_n_out,
  input  wire logic [BSR_LEN-1:0] ring_in,
  input  wire logic               sleep_input_in,
  input  wire logic               address_bit_zero_in,
  input  wire logic               address_bit_one_in,
  output logic                    mem_out_hiz_out,
  output logic                    instr_valid_out,
  output logic      [IR_W-1:0]    instr_code_out,
  input  wire logic               instr_ready_in
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam int CELL_SLEEP = WIDE_VARIANT ? CELL_SLEEP_W : CELL_SLEEP_N;
  localparam int CELL_ADDR1 = WIDE_VARIANT ? CELL_ADDR1_W : CELL_ADDR1_N;
  localparam int CELL_ADDR0 = WIDE_VARIANT ? CELL_ADDR0_W : CELL_ADDR0_N;
  localparam bit [ID_W-1:0] ID_VALUE = {
    REVISION,                                   // [R8]
    WIDE_VARIANT ? DEPTH_WIDE : DEPTH_NARROW,   // [R9]
    WIDE_VARIANT ? WIDTH_WIDE : WIDTH_NARROW,   // [R10]
    DEVICE_CODE,                                // [R12]
    MAKER_CODE,                                 // [R11]
    ID_PRESENT                                  // [R7]
  };

  // ----------------------------------------------------------------
  // Test clock domain reset
  // ----------------------------------------------------------------
  logic trst_n;

  sbst_sync #(.WIDTH(1)) u_trst_sync (
    .clk_in  (tck_in),
    .nrst_in (nrst_in),
    .d_in    (1'h1),
    .q_out   (trst_n)
  );

  // ----------------------------------------------------------------
  // Ring capture path
  // ----------------------------------------------------------------
  logic [BSR_LEN-1:0] ring_vec, ring_q;
  // Named pins take their cells in the chain
  always_comb
  begin
    ring_vec               = ring_in;
    ring_vec[CELL_SLEEP-1] = sleep_input_in;       // [R13]
    ring_vec[CELL_ADDR1-1] = address_bit_one_in;   // [R13]
    ring_vec[CELL_ADDR0-1] = address_bit_zero_in;  // [R13]
  end

  sbst_sync #(.WIDTH(BSR_LEN)) u_ring_sync (
    .clk_in  (tck_in),
    .nrst_in (trst_n),
    .d_in    (ring_vec),
    .q_out   (ring_q)
  );

  // ----------------------------------------------------------------
  // Controller and scan registers
  // ----------------------------------------------------------------
  sbst_state_t        state, next_state;
  logic [IR_W-1:0]    ir, next_ir, ir_shift, next_ir_shift;
  logic [ID_W-1:0]    id_shift, next_id_shift;
  logic [BSR_LEN-1:0] bsr, next_bsr;
  logic               skip, next_skip;
  logic               hiz, next_hiz;
  logic               upd_tgl, next_upd_tgl;
  logic               sel_bsr, sel_id, tdo_bit, shifting;

  assign sel_bsr = (ir == INS_RING_HIZ) || (ir == INS_SAMPLE_HIZ) || (ir == INS_SAMPLE);
  assign sel_id  = (ir == INS_ID_READ);

  always_comb
  begin
    next_state    = state;
    next_ir       = ir;
    next_ir_shift = ir_shift;
    next_id_shift = id_shift;
    next_bsr      = bsr;
    next_skip     = skip;
    next_hiz      = hiz;
    next_upd_tgl  = upd_tgl;
    case (state)                                                   // [R18]
      ST_RESET:  next_state = tms_in ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  next_state = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: next_state = tms_in ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  next_state = tms_in ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: next_state = tms_in ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_in ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  next_state = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: next_state = tms_in ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  next_state = tms_in ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: next_state = tms_in ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: next_state = tms_in ? ST_SEL_DR : ST_IDLE;
      default:   next_state = ST_RESET;
    endcase
    case (state)
      ST_RESET:
      begin
        next_ir  = INS_ID_READ;                                    // [R16]
        next_hiz = 1'b0;                                           // [R16]
      end
      ST_CAP_IR: next_ir_shift = {1'b0, IR_CAPTURE_PAT};           // [R15]
      ST_SH_IR:  next_ir_shift = {tdi_in, ir_shift[IR_W-1:1]};     // [R14] [R17]
      ST_UPD_IR:
      begin
        next_ir      = ir_shift;                                   // [R14]
        next_hiz     = (ir_shift == INS_RING_HIZ)                  // [R1]
                    || (ir_shift == INS_SAMPLE_HIZ);               // [R3]
        next_upd_tgl = ~upd_tgl;
      end
      ST_CAP_DR:
      begin
        if (sel_id)
          next_id_shift = ID_VALUE;                                // [R2]
        else if (sel_bsr)
          next_bsr = ring_q;                                       // [R1] [R3] [R5]
        else
          next_skip = 1'b0;                                        // [R6] [R4]
      end
      ST_SH_DR:
      begin
        if (sel_id)
          next_id_shift = {tdi_in, id_shift[ID_W-1:1]};            // [R2] [R17]
        else if (sel_bsr)
          next_bsr = {tdi_in, bsr[BSR_LEN-1:1]};                   // [R13] [R17]
        else
          next_skip = tdi_in;                                      // [R6] [R4]
      end
      ST_UPD_DR: next_bsr = bsr;                                   // No preload [R5]
      default:   next_skip = skip;
    endcase
  end

  always_ff @(posedge tck_in or negedge trst_n)
  begin
    if (!trst_n)
    begin
      state    <= ST_RESET;
      ir       <= INS_ID_READ;
      ir_shift <= '0;
      id_shift <= '0;
      bsr      <= '0;
      skip     <= 1'b0;
      hiz      <= 1'b0;
      upd_tgl  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      ir       <= next_ir;
      ir_shift <= next_ir_shift;
      id_shift <= next_id_shift;
      bsr      <= next_bsr;
      skip     <= next_skip;
      hiz      <= next_hiz;
      upd_tgl  <= next_upd_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Serial output on falling edge
  // ----------------------------------------------------------------
  assign shifting = (state == ST_SH_DR) || (state == ST_SH_IR);
  assign tdo_bit  = (state == ST_SH_IR) ? ir_shift[0]
                  : sel_id ? id_shift[0] : sel_bsr ? bsr[0] : skip;

  always_ff @(negedge tck_in or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_out      <= 1'b0;
      tdo_oe_n_out <= 1'b1;
    end
    else
    begin
      tdo_out      <= tdo_bit;                                     // [R17]
      tdo_oe_n_out <= !shifting;                                   // [R18]
    end
  end

  // ----------------------------------------------------------------
  // Core clock side
  // ----------------------------------------------------------------
  logic [1:0]      cross_q;
  logic            tgl_seen, pending, next_pending;
  logic [IR_W-1:0] pend_word, next_pend_word;
  logic            fifo_in_ready, fifo_out_valid, fifo_pop, next_instr_valid;
  logic [IR_W-1:0] fifo_out_data, next_instr_code;

  sbst_sync #(.WIDTH(2)) u_core_sync (
    .clk_in  (core_clk_in),
    .nrst_in (nrst_in),
    .d_in    ({upd_tgl, hiz}),
    .q_out   (cross_q)
  );

  assign mem_out_hiz_out = cross_q[0];                             // [R1] [R3]
  assign fifo_pop = !instr_valid_out || instr_ready_in;

  sbst_fifo #(.WIDTH(IR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in        (core_clk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (pending),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pend_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // Word stays stable for many core cycles after each toggle
  always_comb
  begin
    next_pend_word   = pend_word;
    next_pending     = pending && !fifo_in_ready;
    if (cross_q[1] != tgl_seen)
    begin
      next_pending   = 1'b1;
      next_pend_word = ir;
    end
    next_instr_valid = instr_valid_out;
    next_instr_code  = instr_code_out;
    if (fifo_pop)
    begin
      next_instr_valid = fifo_out_valid;
      next_instr_code  = fifo_out_data;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      tgl_seen        <= 1'b0;
      pending         <= 1'b0;
      pend_word       <= '0;
      instr_valid_out <= 1'b0;
      instr_code_out  <= '0;
    end
    else
    begin
      tgl_seen        <= cross_q[1];
      pending         <= next_pending;
      pend_word       <= next_pend_word;
      instr_valid_out <= next_instr_valid;
      instr_code_out  <= next_instr_code;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_tms_reset_five: assert property (@(posedge tck_in) disable iff (!trst_n) // [R16]
    tms_in [*5] |=> (state == ST_RESET))
    else $error("five TMS high edges did not reach reset");
  chk_reset_sel_id: assert property (@(posedge tck_in) disable iff (!trst_n) // [R16]
    (state == ST_RESET) |=> (ir == INS_ID_READ) && !hiz)
    else $error("reset did not select identification");
  chk_capir_pattern: assert property (@(posedge tck_in) disable iff (!trst_n) // [R15]
    (state == ST_CAP_IR) |=> (ir_shift[1:0] == IR_CAPTURE_PAT))
    else $error("instruction capture pattern wrong");
  chk_ir_shift_path: assert property (@(posedge tck_in) disable iff (!trst_n) // [R14]
    (state == ST_SH_IR) |=> (ir_shift == {$past(tdi_in), $past(ir_shift[IR_W-1:1])}))
    else $error("instruction register did not shift");
  chk_id_capture: assert property (@(posedge tck_in) disable iff (!trst_n) // [R7]
    (state == ST_CAP_DR) && sel_id |=> id_shift[0] && (id_shift == ID_VALUE))
    else $error("identification word not loaded");
  chk_hiz_codes: assert property (@(posedge tck_in) disable iff (!trst_n) // [R1]
    (state == ST_UPD_IR) && ((ir_shift == INS_RING_HIZ) || (ir_shift == INS_SAMPLE_HIZ))
    |=> hiz && sel_bsr)
    else $error("floating code did not float outputs");
  chk_sample_no_hiz: assert property (@(posedge tck_in) disable iff (!trst_n) // [R5]
    (state == ST_UPD_IR) && (ir_shift == INS_SAMPLE) |=> !hiz && sel_bsr)
    else $error("sample code disturbed memory outputs");
  chk_ring_capture: assert property (@(posedge tck_in) disable iff (!trst_n) // [R13]
    (state == ST_CAP_DR) && sel_bsr |=> (bsr == $past(ring_q)))
    else $error("boundary chain capture wrong");
  chk_skip_capture: assert property (@(posedge tck_in) disable iff (!trst_n) // [R6]
    (state == ST_CAP_DR) && (ir == INS_SKIP) |=> !skip && !hiz)
    else $error("skip register not cleared on capture");
  chk_tdo_float: assert property (@(posedge tck_in) disable iff (!trst_n) // [R18]
    (state != ST_SH_DR) && (state != ST_SH_IR) |-> tdo_oe_n_out)
    else $error("serial output driven outside shift");

endmodule : sbst_tap

//--- sbst_pkg.sv
// Purpose: Shared constants for the memory test access port
// Assumes: Instruction register three bits wide
// Notes:   Cell numbers count from 1 at the serial output end
package sbst_pkg;

  // ----------------------------------------------------------------
  // Instructions
  // ----------------------------------------------------------------
  localparam int       IR_W           = 3;
  localparam bit [2:0] INS_RING_HIZ   = 3'h0;
  localparam bit [2:0] INS_ID_READ    = 3'h1;
  localparam bit [2:0] INS_SAMPLE_HIZ = 3'h2;
  localparam bit [2:0] INS_SAMPLE     = 3'h4;
  localparam bit [2:0] INS_SKIP       = 3'h7;
  localparam bit [1:0] IR_CAPTURE_PAT = 2'h1;

  // ----------------------------------------------------------------
  // Identification word fields
  // ----------------------------------------------------------------
  localparam int       ID_W         = 32;
  localparam bit       ID_PRESENT   = 1'h1;
  localparam bit [4:0] DEPTH_WIDE   = 5'h07;
  localparam bit [4:0] DEPTH_NARROW = 5'h08;
  localparam bit [4:0] WIDTH_WIDE   = 5'h04;
  localparam bit [4:0] WIDTH_NARROW = 5'h03;

  // ----------------------------------------------------------------
  // Boundary chain
  // ----------------------------------------------------------------
  localparam int BSR_LEN_WIDE   = 70;
  localparam int BSR_LEN_NARROW = 51;
  localparam int CELL_SLEEP_W   = 17;
  localparam int CELL_MEMCLK_W  = 35;
  localparam int CELL_BURST_W   = 64;
  localparam int CELL_ADDR1_W   = 69;
  localparam int CELL_ADDR0_W   = 70;
  localparam int CELL_SLEEP_N   = 12;
  localparam int CELL_ADDR1_N   = 50;
  localparam int CELL_ADDR0_N   = 51;

  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_SEL_DR  = 4'h2,
    ST_CAP_DR  = 4'h3,
    ST_SH_DR   = 4'h4,
    ST_EX1_DR  = 4'h5,
    ST_PA_DR   = 4'h6,
    ST_EX2_DR  = 4'h7,
    ST_UPD_DR  = 4'h8,
    ST_SEL_IR  = 4'h9,
    ST_CAP_IR  = 4'hA,
    ST_SH_IR   = 4'hB,
    ST_EX1_IR  = 4'hC,
    ST_PA_IR   = 4'hD,
    ST_EX2_IR  = 4'hE,
    ST_UPD_IR  = 4'hF
  } sbst_state_t;

endpackage : sbst_pkg

//--- sbst_sync.sv
// Purpose: Two-stage level synchroniser
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second
`timescale 1ns/1ns
module sbst_sync
  import sbst_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule : sbst_sync

//--- sbst_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock
// Notes:   in_ready low when full, out_valid low when empty
`timescale 1ns/1ns
module sbst_fifo
  import sbst_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [CW-1:0]    count, next_count;
  logic             push, pop;

  assign in_ready_out  = (count != CW'(DEPTH));
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push)
    begin
      next_mem[wr_ptr] = in_data_in;
      next_wr_ptr      = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop)
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    next_count = count + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mem    <= '{default: '0};
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule : sbst_fifo

//--- sbst_ctrl_model.sv
// Purpose: Behavioural boundary-scan controller driving the test port
// Assumes: Test clock runs only inside frames, 80 ns period
// Notes:   reset_tap, scan and load_ir leave the port in Run-Test/Idle
`timescale 1ns/1ns
module sbst_ctrl_model
  import sbst_pkg::*;
(
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_n_in
);
  logic pat;

  initial
  begin
    tck_out = 1'h0;
    tms_out = 1'h1;
    tdi_out = 1'h0;
    pat     = 1'h0;
  end

  // ----------------------------------------------------------------
  // Clock steps
  // ----------------------------------------------------------------
  // Inputs change after the fall, output read just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    tms_out = tms;
    tdi_out = tdi;
    #40;
    tdo     = tdo_oe_n_in ? ~tdo_in : tdo_in; // Released line reads inverted
    oe_n    = tdo_oe_n_in;
    tck_out = 1'h1;
    #40;
    tck_out = 1'h0;
  endtask : tick

  // Serial input keeps toggling outside shifts
  task automatic step(input logic tms);
    logic d;
    logic o;
    pat = ~pat;
    tick(tms, pat, d, o);
  endtask : step

  task automatic reset_tap();
    repeat (5) step(1'h1);
    step(1'h0);
  endtask : reset_tap

  // ----------------------------------------------------------------
  // Scans
  // ----------------------------------------------------------------
  task automatic scan(input logic is_ir, input int n, input logic [69:0] din,
                      output logic [69:0] dout, output logic oe_ok);
    logic o;
    dout  = '0;
    oe_ok = 1'h1;
    step(1'h1);
    if (is_ir)
      step(1'h1);
    step(1'h0);
    step(1'h0);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], dout[i], o);
      oe_ok = oe_ok & (o === 1'h0);
    end
    step(1'h1);
    step(1'h0);
    #1;
    oe_ok = oe_ok & (tdo_oe_n_in === 1'h1);
  endtask : scan

  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
    logic [69:0] d;
    logic        ok;
    if (code inside {3'h3, 3'h5, 3'h6})
      code = INS_SKIP;
    scan(1'h1, IR_W, {67'h0, code}, d, ok);
    cap = d[2:0];
  endtask : load_ir
endmodule : sbst_ctrl_model

//--- test_sbst_tap.sv
// Purpose: Self-checking bench of the memory test access port
// Assumes: Wide variant; the controller model owns the test clock
// Notes:   Core side consumer stalls at random
`timescale 1ns/1ns
module test_sbst_tap
  import sbst_pkg::*;
;
  localparam bit [3:0]  REV   = 4'h9;
  localparam bit [5:0]  DEV   = 6'h15;
  localparam bit [10:0] MAKER = 11'h3C6; // Arbitrary maker code
  logic        core_clk, nrst, tck, tms, tdi, tdo, tdo_oe_n;
  logic        sleep, a0, a1, hiz, ivalid, iready, hold;
  logic [69:0] ring;
  logic [2:0]  icode;
  logic [2:0]  got_q[$];
  logic [2:0]  codes[5] = '{INS_RING_HIZ, INS_SAMPLE_HIZ, INS_SAMPLE, INS_SKIP, INS_ID_READ};
  int          errors, num_checks;
  int unsigned seed_v;

  sbst_tap #(.WIDE_VARIANT(1'h1), .REVISION(REV), .DEVICE_CODE(DEV), .MAKER_CODE(MAKER)) uut (
    .core_clk_in         (core_clk),
    .nrst_in             (nrst),
    .tck_in              (tck),
    .tms_in              (tms),
    .tdi_in              (tdi),
    .tdo_out             (tdo),
    .tdo_oe_n_out        (tdo_oe_n),
    .ring_in             (ring),
    .sleep_input_in      (sleep),
    .address_bit_zero_in (a0),
    .address_bit_one_in  (a1),
    .mem_out_hiz_out     (hiz),
    .instr_valid_out     (ivalid),
    .instr_code_out      (icode),
    .instr_ready_in      (iready)
  );

  sbst_ctrl_model ctl (
    .tck_out     (tck),
    .tms_out     (tms),
    .tdi_out     (tdi),
    .tdo_in      (tdo),
    .tdo_oe_n_in (tdo_oe_n)
  );

  // ----------------------------------------------------------------
  // Core clock, consumer and monitor
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  always @(negedge core_clk)
    iready <= hold ? 1'h0 : 1'($urandom % 2);

  always @(posedge core_clk)
    if (ivalid === 1'h1 && iready === 1'h1)
      got_q.push_back(icode);

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check_scan(input string what, input logic [69:0] exp, input logic [69:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_scan

  task automatic check_core(input string what, input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check_core

  function automatic logic [69:0] exp_scan(input logic [2:0] code, input logic [69:0] din);
    logic [69:0] r;
    r                 = ring;
    r[CELL_SLEEP_W-1] = sleep;
    r[CELL_ADDR1_W-1] = a1;
    r[CELL_ADDR0_W-1] = a0;
    case (code)
      INS_ID_READ: exp_scan = {38'h0, REV, DEPTH_WIDE, WIDTH_WIDE, DEV, MAKER, ID_PRESENT};
      INS_SKIP:    exp_scan = {62'h0, din[6:0], 1'h0};
      default:     exp_scan = r;
    endcase
  endfunction : exp_scan

  function automatic int scan_len(input logic [2:0] code);
    return code == INS_SKIP ? 8 : (code == INS_ID_READ ? ID_W : BSR_LEN_WIDE);
  endfunction : scan_len

  task automatic scan_check(input logic [2:0] code);
    logic [69:0] din;
    logic [69:0] dout;
    logic        ok;
    din = 70'({$urandom, $urandom, $urandom});
    ctl.scan(1'h0, scan_len(code), din, dout, ok);
    check_scan("data scan", exp_scan(code, din), dout);
    check_core("enable window", 3'h1, {2'h0, ok});
  endtask : scan_check

  // ----------------------------------------------------------------
  // One instruction: load, float, queue, scan
  // ----------------------------------------------------------------
  task automatic run_code(input logic [2:0] code);
    logic [2:0] cap;
    logic       fl;
    @(negedge core_clk);
    ring  = 70'({$urandom, $urandom, $urandom});
    sleep = 1'($urandom);
    a0    = 1'($urandom);
    a1    = 1'($urandom);
    ctl.load_ir(code, cap);
    check_core("ir capture", {1'h0, IR_CAPTURE_PAT}, {1'h0, cap[1:0]});
    repeat (12) @(negedge core_clk);
    fl = (code == INS_RING_HIZ) || (code == INS_SAMPLE_HIZ);
    check_core("float", {2'h0, fl}, {2'h0, hiz});
    for (int i = 0; i < 60 && got_q.size() == 0; i++)
      @(negedge core_clk);
    check_core("queued code", code, got_q.size() > 0 ? got_q.pop_front() : 3'hX);
    scan_check(code);
  endtask : run_code

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial
  begin
    #2000000;
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0] cap;
    errors     = 0;
    num_checks = 0;
    hold       = 1'h0;
    nrst       = 1'h0;
    iready     = 1'h0;
    sleep      = 1'h0;
    a0         = 1'h0;
    a1         = 1'h0;
    ring       = '0;
    seed_v     = $urandom(5276);
    fork
      repeat (10) @(negedge core_clk);
      ctl.reset_tap();
    join
    @(negedge core_clk);
    nrst = 1'h1;
    ctl.reset_tap();
    check_core("float after reset", 3'h0, {2'h0, hiz});
    scan_check(INS_ID_READ);
    $display("test power reset done");
    repeat (2)
      foreach (codes[k])
        run_code(codes[k]);
    $display("test instruction set done");
    run_code(INS_RING_HIZ);
    ctl.reset_tap();
    repeat (12) @(negedge core_clk);
    check_core("float after tms reset", 3'h0, {2'h0, hiz});
    scan_check(INS_ID_READ);
    $display("test tms reset done");
    hold = 1'h1;
    got_q.delete();
    foreach (codes[k])
      if (k < 4)
        ctl.load_ir(codes[k], cap);
    repeat (20) @(negedge core_clk);
    check_core("stalled queue", 3'h0, 3'(got_q.size()));
    check_core("stalled valid", 3'h1, {2'h0, ivalid});
    hold = 1'h0;
    repeat (80) @(negedge core_clk);
    foreach (codes[k])
      if (k < 4)
        check_core("drained code", codes[k], got_q.size() > 0 ? got_q.pop_front() : 3'hX);
    $display("test queue stall done");
    end_of_test();
  end
endmodule : test_sbst_tap
